/* File: hdl/pbae_map.svh */
// Purpose: Register offsets, field positions and fixed values of the pod bus access engine
// Assumes: Included by the design module; the package does not include it
// Notes: Definitions only
`ifndef PBAE_MAP_SVH
`define PBAE_MAP_SVH

// APB register byte offsets
`define PBAE_OFF_CMD     12'h000
`define PBAE_OFF_ADDR    12'h004
`define PBAE_OFF_DATA    12'h008
`define PBAE_OFF_END     12'h00C
`define PBAE_OFF_STAT    12'h010
`define PBAE_OFF_RDATA   12'h014

// Command register fields
`define PBAE_CMD_OP_LSB  0
`define PBAE_CMD_OP_MSB  2
`define PBAE_CMD_SP_LSB  4
`define PBAE_CMD_SP_MSB  6

// Status register fields
`define PBAE_STAT_BUSY   0
`define PBAE_STAT_REFUSE 1

// Address decoding
`define PBAE_SPECIAL_PFX 16'hF000
`define PBAE_IO_TOP_ZERO 16'h0000
`define PBAE_MEM_TOP_ZERO 8'h00

// Control pin raw levels: lock_n, hold ack, coprocessor ack_n
`define PBAE_CTRL_IDLE   3'h5
`define PBAE_CTRL_LOCK   0
`define PBAE_CTRL_HOLD_ACKNOWLEDGE_OUT   1
`define PBAE_CTRL_COPROCESSOR_OPERAND_ACK_N  2

// Address steps for fill
`define PBAE_STEP_WORD   24'h000002
`define PBAE_STEP_BYTE   24'h000001

// Reset values
`define PBAE_RST_ZERO32  32'h0000_0000
`define PBAE_RST_ZERO24  24'h00_0000
`define PBAE_RST_ZERO16  16'h0000

`endif

/* File: hdl/pbae_pkg.sv */
// Purpose: Types shared by the pod bus access engine
// Assumes: pbae_map.svh holds the numbers
// Notes: Enumerations of commands, spaces and engine states
package pbae_pkg;

   // Commands written to the command register
   typedef enum logic [2:0] {
      PBAE_OP_NONE,
      PBAE_OP_READ,
      PBAE_OP_WRITE,
      PBAE_OP_FILL,
      PBAE_OP_REPEAT,
      PBAE_OP_STATUS,
      PBAE_OP_CTRL,
      PBAE_OP_STOP
   } pbae_op_t;

   // Address-space selector settings
   typedef enum logic [2:0] {
      PBAE_SP_MEM_WORD,
      PBAE_SP_MEM_BYTE,
      PBAE_SP_IO_WORD,
      PBAE_SP_IO_BYTE,
      PBAE_SP_INSTR
   } pbae_space_t;

   typedef enum logic [1:0] {
      PBAE_ST_IDLE,
      PBAE_ST_BUS,
      PBAE_ST_NEXT
   } pbae_state_t;

   // Request toward the unit under test bus
   typedef struct packed {
      logic        req;
      logic        we;
      logic        io;
      logic        byte_acc;
      logic [23:0] addr;
      logic [15:0] wdata;
   } pbae_uut_req_t;

   // Control pins of the emulated processor
   typedef struct packed {
      logic bus_lock_n;
      logic hold_acknowledge_out;
      logic coprocessor_operand_ack_n;
      logic code_or_intack_select;
   } pbae_ctrl_pins_t;

endpackage

/* File: hdl/pbae_engine.sv */
// Purpose: Command engine that turns mainframe commands into unit-under-test bus cycles
// Assumes: APB slave with zero wait states; UUT bus completes a cycle by raising uut_done
// Notes: Special addresses are served from an internal flip-flop array
`timescale 1ns/100ps
`include "pbae_map.svh"

// Summary of operation
// RQ1 - Memory word addresses span 000000 to FFFFFE
// RQ2 - Memory word: 16-bit cycle, even addresses only
// RQ3 - Memory byte: byte cycle at any address
// RQ4 - I/O word: 16-bit cycle, even ports only
// RQ5 - I/O byte: byte cycle, ports 0000 to FFFF
// RQ6 - Five address spaces selectable
// RQ7 - Instruction: word fetch at even address
// RQ8 - Code select high for instruction, low memory
// RQ9 - Writes to instruction space are refused
// RQ10 - Status read returns raw pin levels
// RQ11 - Idle status reports bits 7,6 high
// RQ12 - F000 prefix selects pod internal location
// RQ13 - Special read returns internal 16-bit value
// RQ14 - Special write stores word internally
// RQ15 - Repeat read loops until stop or reset
// RQ16 - Repeated read data is discarded
// RQ17 - Single write drives one bus write
// RQ18 - Fill writes data from start through end
// RQ19 - Control bits give raw lock, hold, coprocessor levels
// RQ20 - Control levels last one access only
// RQ21 - Mainframe sends only in-range values
// RQ22 - Busy from acceptance until done; stop clears (busy stays low for status and special read/write commands)
module pbae_engine import pbae_pkg::*; #(
   parameter int SPECIAL_DEPTH = 16,
   parameter int STATUS_WIDTH = 8
) (
   // APB clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Unit-under-test bus
   output pbae_uut_req_t uut_bus,
   input wire logic [15:0] uut_rdata,
   input wire logic uut_done,
   // Processor status and control pins
   input wire logic [STATUS_WIDTH-1:0] status_in,
   output pbae_ctrl_pins_t ctrl_pins,
   // Engine state toward the mainframe side
   output logic busy
);

   localparam int SIDX_W = $clog2(SPECIAL_DEPTH);

   logic [31:0] addr_q;
   logic [15:0] data_q;
   logic [23:0] end_q;
   logic [15:0] rdata_q;
   logic refuse_q;
   pbae_op_t op_q;
   pbae_space_t space_q;
   pbae_state_t state_q;
   logic [2:0] ctrl_lvl_q;
   logic [23:0] cur_q;
   logic [15:0] special_q [SPECIAL_DEPTH];

   logic wr_en;
   logic rd_en;
   logic cmd_wr;
   pbae_op_t new_op;
   pbae_space_t new_sp;
   logic is_special;
   logic is_word;
   logic is_io;
   logic addr_ok;
   logic accept;
   logic stop_req;
   logic fill_last;
   logic [23:0] step;
   logic [SIDX_W-1:0] sidx;
   logic mapped;

   // APB strobes; the slave never inserts wait states
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign pready = 1'b1;
   assign cmd_wr = wr_en && (paddr == `PBAE_OFF_CMD);
   assign new_op = pbae_op_t'(pwdata[`PBAE_CMD_OP_MSB:`PBAE_CMD_OP_LSB]);
   assign new_sp = pbae_space_t'(pwdata[`PBAE_CMD_SP_MSB:`PBAE_CMD_SP_LSB]);

   // Unmapped offsets answer with an error
   always_comb begin
      unique case (paddr)
         `PBAE_OFF_CMD, `PBAE_OFF_ADDR, `PBAE_OFF_DATA, `PBAE_OFF_END,
         `PBAE_OFF_STAT, `PBAE_OFF_RDATA: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !mapped;

   // Address classification of the command about to start
   assign is_special = (addr_q[31:16] == `PBAE_SPECIAL_PFX); // RQ12
   assign is_word = (new_sp == PBAE_SP_MEM_WORD) || (new_sp == PBAE_SP_IO_WORD)
                    || (new_sp == PBAE_SP_INSTR);
   assign is_io = (new_sp == PBAE_SP_IO_WORD) || (new_sp == PBAE_SP_IO_BYTE);
   assign sidx = addr_q[SIDX_W-1:0];

   // Range checks by space; the mainframe should never break them
   always_comb begin
      addr_ok = 1'b1;
      if (new_sp > PBAE_SP_INSTR) begin
         addr_ok = 1'b0; // RQ6
      end
      if (is_word && addr_q[0]) begin
         addr_ok = 1'b0; // RQ2 RQ4 RQ7
      end
      if (is_io && (addr_q[31:16] != `PBAE_IO_TOP_ZERO)) begin
         addr_ok = 1'b0; // RQ4 RQ5
      end
      if (!is_io && (addr_q[31:24] != `PBAE_MEM_TOP_ZERO)) begin
         addr_ok = 1'b0; // RQ1
      end
      if ((new_op == PBAE_OP_WRITE || new_op == PBAE_OP_FILL) && new_sp == PBAE_SP_INSTR) begin
         addr_ok = 1'b0; // RQ9
      end
      if (new_op == PBAE_OP_STATUS) begin
         addr_ok = 1'b1;
      end
      if (is_special && (new_op == PBAE_OP_READ || new_op == PBAE_OP_WRITE)) begin
         addr_ok = 1'b1;
      end
   end

   // A command starts only from idle; stop is always honoured
   assign stop_req = cmd_wr && (new_op == PBAE_OP_STOP);
   assign accept = cmd_wr && (state_q == PBAE_ST_IDLE) && addr_ok
                   && (new_op != PBAE_OP_STOP) && (new_op != PBAE_OP_NONE);

   // Fill step follows the latched space width
   assign step = (space_q == PBAE_SP_MEM_BYTE || space_q == PBAE_SP_IO_BYTE) ?
                 `PBAE_STEP_BYTE : `PBAE_STEP_WORD;
   assign fill_last = (cur_q >= end_q);

   // Software parameter registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_q <= `PBAE_RST_ZERO32;
         data_q <= `PBAE_RST_ZERO16;
         end_q <= `PBAE_RST_ZERO24;
      end else if (wr_en) begin
         if (paddr == `PBAE_OFF_ADDR) begin
            addr_q <= pwdata;
         end
         if (paddr == `PBAE_OFF_DATA) begin
            data_q <= pwdata[15:0];
         end
         if (paddr == `PBAE_OFF_END) begin
            end_q <= pwdata[23:0];
         end
      end
   end

   // Refusal flag: a new refusal wins over clearing by a good command
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         refuse_q <= 1'b0;
      end else if (cmd_wr && !stop_req && !accept) begin
         refuse_q <= 1'b1; // RQ9
      end else if (accept) begin
         refuse_q <= 1'b0;
      end
   end

   // Pod internal special locations
   generate
      for (genvar i = 0; i < SPECIAL_DEPTH; i++) begin : g_special
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               special_q[i] <= `PBAE_RST_ZERO16;
            end else if (accept && is_special && new_op == PBAE_OP_WRITE && sidx == SIDX_W'(i)) begin
               special_q[i] <= data_q; // RQ14
            end
         end
      end
   endgenerate

   // Sequencer: one bus cycle per pass, looping for fill and repeat
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= PBAE_ST_IDLE;
         op_q <= PBAE_OP_NONE;
         space_q <= PBAE_SP_MEM_WORD;
         cur_q <= `PBAE_RST_ZERO24;
      end else if (stop_req) begin
         state_q <= PBAE_ST_IDLE; // RQ15 RQ22
         op_q <= PBAE_OP_NONE;
      end else begin
         unique case (state_q)
            PBAE_ST_IDLE: begin
               if (accept) begin
                  op_q <= new_op;
                  space_q <= new_sp;
                  cur_q <= addr_q[23:0];
                  // Special read/write and status commands finish without a bus cycle
                  if (!(is_special && (new_op == PBAE_OP_READ || new_op == PBAE_OP_WRITE))
                      && new_op != PBAE_OP_STATUS) begin
                     state_q <= PBAE_ST_BUS; // RQ12
                  end
               end
            end
            PBAE_ST_BUS: begin
               if (uut_done) begin
                  state_q <= PBAE_ST_NEXT;
               end
            end
            PBAE_ST_NEXT: begin
               if (op_q == PBAE_OP_REPEAT) begin
                  state_q <= PBAE_ST_BUS; // RQ15
               end else if (op_q == PBAE_OP_FILL && !fill_last) begin
                  cur_q <= cur_q + step; // RQ18
                  state_q <= PBAE_ST_BUS;
               end else begin
                  state_q <= PBAE_ST_IDLE;
                  op_q <= PBAE_OP_NONE;
               end
            end
            default: begin
               state_q <= PBAE_ST_IDLE;
            end
         endcase
      end
   end

   // Result capture; repeated reads never update it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= `PBAE_RST_ZERO16;
      end else if (accept && new_op == PBAE_OP_STATUS) begin
         rdata_q <= 16'(status_in); // RQ10 RQ11
      end else if (accept && is_special && new_op == PBAE_OP_READ) begin
         rdata_q <= special_q[sidx]; // RQ13
      end else if (state_q == PBAE_ST_BUS && uut_done && op_q == PBAE_OP_READ) begin
         if (space_q == PBAE_SP_MEM_BYTE || space_q == PBAE_SP_IO_BYTE) begin
            rdata_q <= {8'h00, uut_rdata[7:0]}; // RQ3 RQ5
         end else begin
            rdata_q <= uut_rdata; // RQ2 RQ4 RQ7
         end
      end
   end // RQ16

   // Control levels latched per command, held only for its access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_lvl_q <= `PBAE_CTRL_IDLE;
      end else if (accept && new_op == PBAE_OP_CTRL) begin
         ctrl_lvl_q <= data_q[2:0]; // RQ19
      end else if (state_q == PBAE_ST_NEXT || stop_req) begin
         ctrl_lvl_q <= `PBAE_CTRL_IDLE; // RQ20
      end
   end

   // Bus request outputs; request falls on completion or stop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         uut_bus <= '0;
         ctrl_pins <= '{bus_lock_n: 1'b1, hold_acknowledge_out: 1'b0,
                        coprocessor_operand_ack_n: 1'b1, code_or_intack_select: 1'b0};
      end else begin
         uut_bus.req <= (state_q == PBAE_ST_BUS) && !uut_done && !stop_req;
         uut_bus.we <= (op_q == PBAE_OP_WRITE) || (op_q == PBAE_OP_FILL); // RQ17 RQ18
         uut_bus.io <= (space_q == PBAE_SP_IO_WORD) || (space_q == PBAE_SP_IO_BYTE);
         uut_bus.byte_acc <= (space_q == PBAE_SP_MEM_BYTE) || (space_q == PBAE_SP_IO_BYTE);
         uut_bus.addr <= cur_q;
         uut_bus.wdata <= data_q;
         ctrl_pins.bus_lock_n <= ctrl_lvl_q[`PBAE_CTRL_LOCK]; // RQ19
         ctrl_pins.hold_acknowledge_out <= ctrl_lvl_q[`PBAE_CTRL_HOLD_ACKNOWLEDGE_OUT];
         ctrl_pins.coprocessor_operand_ack_n <= ctrl_lvl_q[`PBAE_CTRL_COPROCESSOR_OPERAND_ACK_N];
         ctrl_pins.code_or_intack_select <= (space_q == PBAE_SP_INSTR) && (state_q != PBAE_ST_IDLE); // RQ8
      end
   end

   // Busy covers every accepted command that starts a bus cycle until its last cycle; status and special read/write never raise it
   assign busy = (state_q != PBAE_ST_IDLE); // RQ22

   // Register read mux
   always_comb begin
      prdata = `PBAE_RST_ZERO32;
      if (rd_en) begin
         unique case (paddr)
            `PBAE_OFF_CMD: prdata = {25'h0, space_q, 1'b0, op_q};
            `PBAE_OFF_ADDR: prdata = addr_q;
            `PBAE_OFF_DATA: prdata = {16'h0000, data_q};
            `PBAE_OFF_END: prdata = {8'h00, end_q};
            `PBAE_OFF_STAT: prdata = {30'h0, refuse_q, busy};
            `PBAE_OFF_RDATA: prdata = {16'h0000, rdata_q};
            default: prdata = `PBAE_RST_ZERO32;
         endcase
      end
   end

endmodule

/* File: dv/pbae_engine_asserts.sv */
// Purpose: Port-level checks of the pod bus access engine
// Assumes: One clock pclk, asynchronous active-low presetn
// Notes: Bound into every engine instance
`timescale 1ns/100ps
module pbae_engine_asserts import pbae_pkg::*; #(
   parameter int STATUS_WIDTH = 8
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB side
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // UUT side and pins
   input wire pbae_uut_req_t uut_bus,
   input wire logic [15:0] uut_rdata,
   input wire logic uut_done,
   input wire logic [STATUS_WIDTH-1:0] status_in,
   input wire pbae_ctrl_pins_t ctrl_pins,
   input wire logic busy
);
   // Stop command taken on this edge
   wire stop_wr = psel && penable && pwrite && paddr == 12'h000 && pwdata[2:0] == 3'h7;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Cycle shape on the UUT bus
   a_word_even: assert property (uut_bus.req && !uut_bus.byte_acc |-> !uut_bus.addr[0])
      else $error("word cycle at odd address");
   a_io_range: assert property (uut_bus.req && uut_bus.io |-> uut_bus.addr[23:16] == 8'h00)
      else $error("port address above 16 bits");
   a_code_instr: assert property (uut_bus.req && ctrl_pins.code_or_intack_select |-> !uut_bus.we && !uut_bus.io)
      else $error("code select on write or port cycle");
   a_req_holds: assert property (uut_bus.req && !uut_done && !stop_wr |=> uut_bus.req && $stable(uut_bus.addr) && $stable(uut_bus.wdata))
      else $error("request changed before completion");
   a_done_ends: assert property (uut_bus.req && uut_done |=> !uut_bus.req)
      else $error("request kept after completion");
   // Busy and stop
   a_busy_req: assert property (uut_bus.req |-> busy)
      else $error("bus request while not busy");
   a_stop_clears: assert property (stop_wr |=> !busy && !uut_bus.req)
      else $error("stop left engine running");
   a_ctrl_idle: assert property (!busy && !$past(busy) |-> ctrl_pins == 4'b1010)
      else $error("control pins not idle");
endmodule

bind pbae_engine pbae_engine_asserts #(.STATUS_WIDTH(STATUS_WIDTH)) u_asserts (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .uut_bus, .uut_rdata, .uut_done, .status_in, .ctrl_pins, .busy);

/* File: dv/pbae_uut_model.sv */
// Purpose: Behavioural unit-under-test bus responder
// Assumes: Requests stand until uut_done
// Notes: Unwritten bytes read as 3C; read data toggles when idle
`timescale 1ns/100ps
module pbae_uut_model import pbae_pkg::*; (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bus from the engine
   input wire pbae_uut_req_t uut_bus,
   input wire logic slow,
   output logic [15:0] uut_rdata,
   output logic uut_done
);
   logic [7:0] mem [int];
   int wait_q, n_reads, k;
   function automatic logic [7:0] rdb(input int a);
      return mem.exists(a) ? mem[a] : 8'h3C;
   endfunction
   // One completion per request; slow mode adds three wait cycles
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         uut_done <= 1'b0;
         wait_q <= 0;
         n_reads <= 0;
         uut_rdata <= 16'hA5A5;
      end else if (uut_bus.req && !uut_done && wait_q < (slow ? 3 : 0)) begin
         wait_q <= wait_q + 1;
         uut_rdata <= ~uut_rdata;
      end else if (uut_bus.req && !uut_done) begin
         k = {7'h00, uut_bus.io, uut_bus.addr};
         uut_done <= 1'b1;
         wait_q <= 0;
         if (uut_bus.we) begin
            mem[k] = uut_bus.wdata[7:0];
            if (!uut_bus.byte_acc) mem[k + 1] = uut_bus.wdata[15:8];
         end else begin
            n_reads <= n_reads + 1;
            // Garbage high lane on byte reads
            uut_rdata <= {uut_bus.byte_acc ? ~rdb(k + 1) : rdb(k + 1), rdb(k)};
         end
      end else begin
         uut_done <= 1'b0;
         uut_rdata <= ~uut_rdata;
      end
   end
endmodule

/* File: dv/tb_top.sv */
// Purpose: Self-checking bench of the pod bus access engine
// Assumes: Zero-wait APB, partner model on the UUT bus
// Notes: Expected memory kept as a byte map
`timescale 1ns/100ps
module tb_top;
   import pbae_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, st, seed = 32'h05B0D615;
   logic pready, pslverr, uut_done, busy, saw_req, err_q;
   logic [15:0] uut_rdata, d;
   logic [7:0] status_in = 8'h00;
   logic [23:0] a, am;
   logic [23:0] tab [5] = '{24'hFFFFFE, 24'h123457, 24'h00FFFE, 24'h00FFFF, 24'hFFFFFE};
   pbae_uut_req_t uut_bus;
   pbae_ctrl_pins_t ctrl_pins, snap;
   logic [7:0] exp_m [int];
   int n_errors = 0, cmp_count = 0, cyc = 0, k, n0;
   // Clock
   always #5 pclk = ~pclk;
   pbae_engine uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .uut_bus, .uut_rdata, .uut_done, .status_in, .ctrl_pins, .busy);
   pbae_uut_model partner (.pclk, .presetn, .uut_bus, .slow, .uut_rdata, .uut_done);
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [7:0] em(input int i);
      return exp_m.exists(i) ? exp_m[i] : 8'h3C;
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task complete_run;
      if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // One APB transfer; request held until pready is sampled
   task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Command, wait for idle, then fetch status and result
   task cmd(input logic [2:0] op, input logic [2:0] sp);
      apb(1'b1, 12'h000, {25'h0, sp, 1'b0, op});
      saw_req = 1'b0;
      for (int n = 0; n < 400; n++) begin
         @(posedge pclk);
         if (uut_bus.req === 1'b1) begin
            saw_req = 1'b1;
            snap = ctrl_pins;
         end
         if (n > 0 && busy !== 1'b1) break;
      end
      apb(1'b0, 12'h010, 32'h0);
      st = rd;
      apb(1'b0, 12'h014, 32'h0);
   endtask
   // Hang guard
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         complete_run();
      end
   end
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      chk({busy, ctrl_pins}, 5'b01010);
      // Every space: boundary addresses except 123457 for memory byte, then random ones
      for (int p = 0; p < 2; p++) begin
         slow <= p[0];
         for (int sp = 0; sp < 5; sp++) begin
            a = p ? seed[23:0] & (sp < 2 ? 24'hFFFFFF : 24'h00FFFF) & (sp[0] ? 24'hFFFFFF : 24'hFFFFFE) : tab[sp];
            if (sp == 0) am = a;
            if (sp == 4) a = am;
            d = seed[31:16];
            seed = lfsr(seed);
            k = {7'h00, sp == 2 || sp == 3, a};
            apb(1'b1, 12'h004, {8'h00, a});
            apb(1'b1, 12'h008, {16'h0000, d});
            cmd(3'h2, sp[2:0]);
            chk(st[1], sp == 4);
            if (sp != 4) exp_m[k] = d[7:0];
            if (sp == 0 || sp == 2) exp_m[k + 1] = d[15:8];
            cmd(3'h1, sp[2:0]);
            chk(snap.code_or_intack_select, sp == 4);
            chk(rd, sp[0] ? {24'h0, em(k)} : {16'h0, em(k + 1), em(k)});
         end
      end
      status_in <= 8'hC0;
      cmd(3'h5, 3'h0);
      chk(rd, 32'h0000_00C0);
      status_in <= seed[7:0];
      cmd(3'h5, 3'h0);
      chk(rd, {24'h0, status_in});
      d = seed[23:8];
      apb(1'b1, 12'h004, 32'hF000_0003);
      apb(1'b1, 12'h008, {16'h0000, d});
      cmd(3'h2, 3'h0);
      chk(saw_req, 1'b0);
      apb(1'b1, 12'h008, 32'h0);
      cmd(3'h1, 3'h0);
      chk(rd, {16'h0, d});
      // Fill a word range, then read one past its end
      d = seed[15:0];
      apb(1'b1, 12'h004, 32'h0000_0200);
      apb(1'b1, 12'h00C, 32'h0000_0206);
      apb(1'b1, 12'h008, {16'h0000, d});
      cmd(3'h3, 3'h0);
      for (k = 32'h200; k < 32'h208; k++) exp_m[k] = k[0] ? d[15:8] : d[7:0];
      for (k = 32'h200; k <= 32'h208; k += 2) begin
         apb(1'b1, 12'h004, k);
         cmd(3'h1, 3'h0);
         chk(rd, {16'h0, em(k + 1), em(k)});
      end
      // Repeated reads against a slow partner, then stop
      st = rd;
      slow <= 1'b1;
      apb(1'b1, 12'h004, 32'h0000_0200);
      n0 = partner.n_reads;
      apb(1'b1, 12'h000, 32'h0000_0004);
      repeat (40) @(posedge pclk);
      chk(partner.n_reads - n0 > 4, 1'b1);
      chk(busy, 1'b1);
      apb(1'b0, 12'h014, 32'h0);
      chk(rd, st);
      apb(1'b1, 12'h000, 32'h0000_0007);
      @(posedge pclk);
      chk({busy, uut_bus.req}, 2'b00);
      slow <= 1'b0;
      apb(1'b1, 12'h008, 32'h0000_0002);
      cmd(3'h6, 3'h0);
      chk(snap, 4'b0100);
      chk(ctrl_pins, 4'b1010);
      apb(1'b0, 12'h018, 32'h0);
      chk(err_q, 1'b1);
      complete_run();
   end
endmodule
